// ---- verilog/tws_pkg.sv ----
// constants, state codes and field layouts for the two-wire display ram slave
// assumes a single core clock domain; link pins are sampled, not clocked on
package tws_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // interface select strap value for two-wire mode (low, high)
  localparam logic [1:0] MODE_I2C = 2'h1;

  // header byte layout: prefix, chip-select bits, type bit, direction bit
  // prefix value is arbitrary
  localparam logic [3:0] DEV_ADDR_PREFIX = 4'h7;
  localparam int HDR_PREFIX_LSB = 4;
  localparam int HDR_ADDR_LSB = 2;
  localparam int HDR_CD_BIT = 1;
  localparam int HDR_RW_BIT = 0;

  // acknowledge levels driven by the slave
  localparam logic ACK_GOOD = 1'b1;
  localparam logic ACK_BAD = 1'b0;

  // bits per byte on the link
  localparam logic [3:0] BIT_COUNT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // display ram geometry
  localparam int PAGE_W = 4;
  localparam int COL_W = 7;
  localparam logic [6:0] COL_LAST = 7'h65;
  localparam logic [6:0] COL_END = 7'h66;
  localparam logic [3:0] PAGE_LAST_GFX = 4'h7;
  localparam logic [3:0] PAGE_ICON = 4'h8;
  localparam logic [9:0] COL_COUNT = 10'h066;
  localparam int RAM_DEPTH = 918;

  // address commands: upper nibble selects, lower nibble carries the value
  localparam logic [3:0] CMD_COL_LO = 4'h0;
  localparam logic [3:0] CMD_COL_HI = 4'h1;
  localparam logic [3:0] CMD_PAGE = 4'hb;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HDR,
    ST_HDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_SKIP
  } tws_state_e;

endpackage

// ---- verilog/tws_addr_if.sv ----
// host-side ram address counter controls and the current page and column
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface tws_addr_if;
  logic set_col_lo;
  logic set_col_hi;
  logic set_page;
  logic [3:0] set_val;
  logic step;
  logic wrap_en;
  logic step_dir;
  logic [3:0] page;
  logic [6:0] col;

  modport ctrl (
    output set_col_lo,
    output set_col_hi,
    output set_page,
    output set_val,
    output step,
    output wrap_en,
    output step_dir,
    input page,
    input col
  );

  modport ctr (
    input set_col_lo,
    input set_col_hi,
    input set_page,
    input set_val,
    input step,
    input wrap_en,
    input step_dir,
    output page,
    output col
  );
endinterface

// ---- verilog/tws_addr_counter.sv ----
// page and column counter for host accesses to the display ram
// assumes the controls are single-cycle strobes from the core clock domain
`timescale 1ns/1ps
module tws_addr_counter (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  tws_addr_if.ctr addr
);
  import tws_pkg::*;

  typedef struct packed {
    logic [3:0] page;
    logic [6:0] col;
  } tws_ctr_s;

  tws_ctr_s st_reg;
  tws_ctr_s st_next;

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    if (addr.set_col_lo)
    begin
      st_next.col[3:0] = addr.set_val;
    end
    else if (addr.set_col_hi)
    begin
      st_next.col[6:4] = addr.set_val[2:0];
    end
    else if (addr.set_page)
    begin
      st_next.page = addr.set_val;
    end
    else if (addr.step)
    begin
      if (st_reg.col >= COL_END)
      begin
        // parked at end of page until software reloads
        st_next.col = COL_END;
      end
      else if (addr.wrap_en && st_reg.page <= PAGE_LAST_GFX && st_reg.col == COL_LAST)
      begin
        st_next.col = 7'h00;
        if (addr.step_dir)
        begin
          st_next.page = (st_reg.page == 4'h0) ? PAGE_LAST_GFX : st_reg.page - 4'h1;
        end
        else
        begin
          st_next.page = (st_reg.page == PAGE_LAST_GFX) ? 4'h0 : st_reg.page + 4'h1;
        end
      end
      else
      begin
        // icon page never wraps, so it simply runs up to the end
        st_next.col = st_reg.col + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign addr.page = st_reg.page;
  assign addr.col = st_reg.col;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  wire plain_step = addr.step && !addr.set_col_lo && !addr.set_col_hi && !addr.set_page;

  AST_COL_STOP: assert property (
    (plain_step && !addr.wrap_en && st_reg.col == COL_LAST) |=> (st_reg.col == COL_END)
  ) else $error("column moved past end of page with wrap off");

  AST_COL_WRAP: assert property (
    (plain_step && addr.wrap_en && st_reg.page < PAGE_ICON && st_reg.col == COL_LAST)
      |=> (st_reg.col == 7'h00)
  ) else $error("column did not return to zero on wrap");

  AST_PAGE_WRAP: assert property (
    (plain_step && addr.wrap_en && !addr.step_dir && st_reg.page == PAGE_LAST_GFX
      && st_reg.col == COL_LAST) |=> (st_reg.page == 4'h0)
  ) else $error("page did not wrap from last graphics page");

  AST_ICON_STOP: assert property (
    (plain_step && st_reg.page == PAGE_ICON && st_reg.col == COL_LAST)
      |=> (st_reg.col == COL_END && st_reg.page == PAGE_ICON) ##1 (st_reg.page == PAGE_ICON)
  ) else $error("icon page did not stop at column end");

endmodule

// ---- verilog/tws_i2c_slave.sv ----
// two-wire serial slave with display ram and host address counters
// assumes scl and sda come from pins and are oversampled by the core clock;
// the sda wire is resolved outside from sda_o and sda_oe_o
`timescale 1ns/1ps
module tws_i2c_slave (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] interface_select_pins_i,
  input wire logic [1:0] chip_select_addr_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic column_mirror_i,
  input wire logic byte_bit_order_i,
  input wire logic page_wrap_enable_i,
  input wire logic page_step_direction_i,
  input wire logic [tws_pkg::PAGE_W-1:0] disp_page_i,
  input wire logic [tws_pkg::COL_W-1:0] disp_col_i,
  output logic [7:0] disp_data_o,
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o,
  output logic [tws_pkg::PAGE_W-1:0] page_addr_o,
  output logic [tws_pkg::COL_W-1:0] column_addr_o
);
  import tws_pkg::*;

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic scl_d;
    logic sda_d;
    tws_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic cd;
    logic ack_ok;
    logic nack;
    logic [7:0] rd_pipe;
    logic sda_o;
    logic sda_oe;
    logic [7:0] cmd_byte;
    logic cmd_valid;
    logic [7:0] disp_data;
  } tws_main_s;

  tws_main_s st_reg;
  tws_main_s st_next;

  tws_addr_if addr ();

  tws_addr_counter u_addr_counter (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .addr(addr.ctr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pin view; only sync2 and later are looked at
  logic scl;
  logic sda;
  logic mode_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic hdr_match;

  assign scl = st_reg.sync2[5];
  assign sda = st_reg.sync2[4];
  assign mode_ok = (st_reg.sync2[3:2] == MODE_I2C);
  assign scl_rise = scl && !st_reg.scl_d;
  assign scl_fall = !scl && st_reg.scl_d;
  assign start_det = scl && st_reg.scl_d && st_reg.sda_d && !sda;
  assign stop_det = scl && st_reg.scl_d && !st_reg.sda_d && sda;
  // write strobe and cd pins are not part of the address
  assign hdr_match = (st_reg.shift[7:HDR_PREFIX_LSB] == DEV_ADDR_PREFIX)
    && (st_reg.shift[HDR_ADDR_LSB+1:HDR_ADDR_LSB] == st_reg.sync2[1:0]);

  //////////////////////////////////////////////////////////////////////////////
  // display ram: 8 graphics pages plus the icon page, one byte per column
  logic [7:0] ram [RAM_DEPTH];
  logic [6:0] phys_col;
  logic host_ok;
  logic [9:0] host_idx;
  logic disp_ok;
  logic [9:0] disp_idx;
  logic [7:0] ram_raw;
  logic [7:0] rx_rev;
  logic [7:0] raw_rev;
  logic [7:0] store_byte;
  logic [7:0] host_rdata;
  logic [7:0] disp_word;
  logic ram_we;

  // mirroring is applied on the way in, so stored data keeps its old place
  assign phys_col = column_mirror_i ? (COL_LAST - addr.col) : addr.col;
  assign host_ok = (addr.col <= COL_LAST) && (addr.page <= PAGE_ICON);
  // byte n of every page feeds pixel column n
  assign host_idx = 10'({6'h00, addr.page} * COL_COUNT) + {3'h0, phys_col};
  assign disp_ok = (disp_col_i <= COL_LAST) && (disp_page_i <= PAGE_ICON);
  assign disp_idx = 10'({6'h00, disp_page_i} * COL_COUNT) + {3'h0, disp_col_i};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      assign rx_rev[gi] = st_reg.shift[7-gi];
      assign raw_rev[gi] = ram_raw[7-gi];
    end
  endgenerate

  assign ram_raw = host_ok ? ram[host_idx] : 8'h00;
  assign store_byte = byte_bit_order_i ? st_reg.shift : rx_rev;
  assign host_rdata = byte_bit_order_i ? ram_raw : raw_rev;
  // second read port serves the display scan with no arbitration
  assign disp_word = disp_ok ? ram[disp_idx] : 8'h00;

  always_ff @(posedge core_clk_i)
  begin
    if (ram_we)
    begin
      ram[host_idx] <= store_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  logic do_load;
  logic ack_ok;
  logic [7:0] tx_byte;

  // control reads return the current page, a cheap status view
  assign tx_byte = st_reg.cd ? st_reg.rd_pipe : {4'h0, addr.page};
  assign addr.wrap_en = page_wrap_enable_i;
  assign addr.step_dir = page_step_direction_i;
  assign addr.set_val = st_reg.shift[3:0];

  always_comb
  begin
    st_next = st_reg;
    do_load = 1'b0;
    ack_ok = 1'b1;
    ram_we = 1'b0;
    addr.set_col_lo = 1'b0;
    addr.set_col_hi = 1'b0;
    addr.set_page = 1'b0;
    addr.step = 1'b0;
    st_next.sync1 = {scl_i, sda_i, interface_select_pins_i, chip_select_addr_i};
    st_next.sync2 = st_reg.sync1;
    st_next.scl_d = scl;
    st_next.sda_d = sda;
    st_next.cmd_valid = 1'b0;
    st_next.disp_data = disp_word;
    if (!mode_ok)
    begin
      // other strap settings leave the link untouched
      st_next.state = ST_IDLE;
      st_next.sda_oe = 1'b0;
    end
    else if (start_det)
    begin
      st_next.state = ST_HDR;
      st_next.bit_cnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end
    else if (stop_det)
    begin
      st_next.state = ST_IDLE;
      st_next.sda_oe = 1'b0;
    end
    else
    begin
      case (st_reg.state)
        ST_HDR, ST_WR_BYTE:
        begin
          if (scl_rise)
          begin
            st_next.shift = {st_reg.shift[6:0], sda};
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && st_reg.bit_cnt == BIT_COUNT)
          begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.state == ST_HDR)
            begin
              if (hdr_match)
              begin
                st_next.rw = st_reg.shift[HDR_RW_BIT];
                st_next.cd = st_reg.shift[HDR_CD_BIT];
                st_next.state = ST_HDR_ACK;
                st_next.sda_o = ACK_GOOD;
                st_next.sda_oe = 1'b1;
              end
              else
              begin
                st_next.state = ST_SKIP;
              end
            end
            else
            begin
              if (st_reg.cd)
              begin
                // no room past the page end: refuse so the master resends
                ack_ok = host_ok;
                ram_we = host_ok;
                addr.step = host_ok;
              end
              else
              begin
                st_next.cmd_byte = st_reg.shift;
                st_next.cmd_valid = 1'b1;
                // address set commands load the counters
                addr.set_col_lo = (st_reg.shift[7:4] == CMD_COL_LO);
                addr.set_col_hi = (st_reg.shift[7:4] == CMD_COL_HI);
                addr.set_page = (st_reg.shift[7:4] == CMD_PAGE);
              end
              st_next.ack_ok = ack_ok;
              st_next.state = ST_WR_ACK;
              st_next.sda_o = ack_ok ? ACK_GOOD : ACK_BAD;
              st_next.sda_oe = 1'b1;
            end
          end
        end
        ST_HDR_ACK, ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            if (st_reg.state == ST_HDR_ACK && st_reg.rw)
            begin
              do_load = 1'b1;
            end
            else
            begin
              st_next.sda_oe = 1'b0;
              st_next.state = ST_WR_BYTE;
            end
          end
        end
        ST_RD_BYTE:
        begin
          if (scl_rise)
          begin
            st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (st_reg.bit_cnt == BIT_COUNT)
            begin
              st_next.sda_oe = 1'b0;
              st_next.state = ST_RD_ACK;
            end
            else
            begin
              st_next.shift = {st_reg.shift[6:0], 1'b0};
              st_next.sda_o = st_reg.shift[6];
            end
          end
        end
        ST_RD_ACK:
        begin
          if (scl_rise)
          begin
            st_next.nack = sda;
          end
          else if (scl_fall)
          begin
            if (st_reg.nack)
            begin
              st_next.state = ST_SKIP;
            end
            else
            begin
              do_load = 1'b1;
            end
          end
        end
        ST_IDLE, ST_SKIP:
        begin
          st_next.sda_oe = 1'b0;
        end
        default:
        begin
          st_next.state = ST_IDLE;
          st_next.sda_oe = 1'b0;
        end
      endcase
      if (do_load)
      begin
        // two-stage read: send the held byte, fetch the next one
        st_next.shift = tx_byte;
        st_next.sda_o = tx_byte[7];
        st_next.sda_oe = 1'b1;
        st_next.bit_cnt = 4'h0;
        st_next.state = ST_RD_BYTE;
        if (st_reg.cd)
        begin
          st_next.rd_pipe = host_rdata;
          addr.step = host_ok;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '0;
      st_reg.sync1 <= 6'h3c;
      st_reg.sync2 <= 6'h3c;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.state <= ST_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sda_o = st_reg.sda_o;
  assign sda_oe_o = st_reg.sda_oe;
  assign disp_data_o = st_reg.disp_data;
  assign cmd_byte_o = st_reg.cmd_byte;
  assign cmd_valid_o = st_reg.cmd_valid;
  assign page_addr_o = addr.page;
  assign column_addr_o = addr.col;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic xfer_busy;
  logic tx_next_bit;
  logic link_quiet;
  assign xfer_busy = st_reg.state inside {ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK};
  assign tx_next_bit = st_reg.shift[6];
  assign link_quiet = mode_ok && !start_det && !stop_det;

  AST_NO_DRIVE_OFF_MODE: assert property (
    (!mode_ok && !$past(mode_ok)) |-> !sda_oe_o
  ) else $error("sda driven outside two-wire mode");

  AST_HDR_MATCH: assert property (
    (st_reg.state == ST_HDR && scl_fall && st_reg.bit_cnt == BIT_COUNT && link_quiet)
      |=> (st_reg.state == (($past(hdr_match)) ? ST_HDR_ACK : ST_SKIP))
  ) else $error("header address decode wrong");

  AST_HDR_ACK_GOOD: assert property (
    (st_reg.state == ST_HDR_ACK && sda_oe_o) |-> (sda_o == ACK_GOOD)
  ) else $error("header acknowledge level wrong");

  AST_TYPE_HELD: assert property (
    (xfer_busy && $past(xfer_busy)) |-> ($stable(st_reg.cd) && $stable(st_reg.rw))
  ) else $error("transfer type changed inside a sequence");

  AST_MSB_FIRST: assert property (
    (st_reg.state == ST_RD_BYTE && scl_fall && st_reg.bit_cnt < BIT_COUNT && link_quiet)
      |=> (sda_o == $past(tx_next_bit))
  ) else $error("read bit order wrong");

  AST_DUMMY_FIRST: assert property (
    (st_reg.state == ST_HDR_ACK && scl_fall && st_reg.rw && st_reg.cd && link_quiet)
      |=> (st_reg.shift == $past(st_reg.rd_pipe)) ##1 (st_reg.state == ST_RD_BYTE)
  ) else $error("first data read byte not the held dummy");

  AST_START_HDR: assert property (
    (mode_ok && start_det) |=> (st_reg.state == ST_HDR && st_reg.bit_cnt == 4'h0)
  ) else $error("start not taken");

  AST_STOP_IDLE: assert property (
    (mode_ok && stop_det) |=> (st_reg.state == ST_IDLE && !sda_oe_o)
  ) else $error("stop not taken");

  AST_DRIVE_SCL_LOW: assert property (
    (sda_oe_o && $past(sda_oe_o) && $changed(sda_o)) |-> !scl
  ) else $error("sda changed while scl high");

  AST_ACK_SLOT: assert property (
    (st_reg.state == ST_WR_BYTE && scl_fall && st_reg.bit_cnt == BIT_COUNT && link_quiet)
      |=> (sda_oe_o && st_reg.state == ST_WR_ACK)
  ) else $error("no acknowledge after eight written bits");

  AST_ACK_LEVEL: assert property (
    (st_reg.state == ST_WR_ACK && sda_oe_o)
      |-> (sda_o == (st_reg.ack_ok ? ACK_GOOD : ACK_BAD))
  ) else $error("write acknowledge level wrong");

  COV_HDR_ACK: cover property (st_reg.state == ST_HDR_ACK && scl_fall);
  COV_DATA_WRITE: cover property (ram_we);
  COV_READ_NACK: cover property (st_reg.state == ST_RD_ACK && scl_fall && st_reg.nack);
  COV_WRITE_REFUSED: cover property (st_reg.state == ST_WR_ACK && !st_reg.ack_ok);

endmodule

// ---- dv/tws_master_model.sv ----
// two-wire bus master model driving the link clock and pulling sda low
// assumes the bench resolves sda from both parties with a pull-up
`timescale 1ns/1ps
module tws_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic [7:0] rx_o,
  output logic rx_tgl_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rx_o = 8'h00;
    rx_tgl_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // scl stands high between frames; long low phase leaves the slave room
  task automatic bit_io(input logic b, output logic s);
    #400 sda_low_o = ~b;
    #100 scl_o = 1'b1;
    #150 s = sda_i;
    #150 scl_o = 1'b0;
  endtask
  task automatic start();
    #400 sda_low_o = 1'b1;
    #400 scl_o = 1'b0;
  endtask
  task automatic stop();
    #400 sda_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #300 sda_low_o = 1'b0;
    #400;
  endtask
  // wr=1 sends b and reports the ack; wr=0 reports the byte, answers ak
  task automatic xfer(input logic wr, input logic [7:0] b, input logic ak);
    logic s;
    logic [7:0] r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(wr ? b[i] : 1'b1, s);
      r[i] = s;
    end
    bit_io(wr ? 1'b1 : ak, s);
    rx_o = wr ? {7'h00, s} : r;
    rx_tgl_o = ~rx_tgl_o;
  endtask
endmodule

// ---- dv/two_wire_slave_display_ram_addressing_tb.sv ----
// self-checking bench: master model on the link, notes queued per result
// assumes the slave answers within the slow master's low phase
`timescale 1ns/1ps
module two_wire_slave_display_ram_addressing_tb;
  import tws_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] sel = 2'h3;
  logic [1:0] cs = 2'h0;
  logic mir = 1'b0;
  logic ord = 1'b1;
  logic wrp = 1'b0;
  logic dir = 1'b0;
  logic [3:0] dpg = 4'h0;
  logic [6:0] dcl = 7'h00;
  logic sda_d, sda_oe, cmdv, scl, mlow, rxt, probe = 1'b0;
  logic [7:0] ddat, cmd, rx, d;
  logic [7:0] oe_cnt = 8'h00;
  logic [3:0] pg;
  logic [6:0] cl;
  logic [31:0] rs = 32'hf2089056;
  logic [18:0] nq[$];
  logic [7:0] cq[$];
  int err_total = 0;
  int samples_checked = 0;
  wire sda = mlow ? 1'b0 : (sda_oe ? sda_d : 1'b1);
  tws_i2c_slave i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .interface_select_pins_i(sel),
    .chip_select_addr_i(cs), .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe),
    .column_mirror_i(mir), .byte_bit_order_i(ord), .page_wrap_enable_i(wrp),
    .page_step_direction_i(dir), .disp_page_i(dpg), .disp_col_i(dcl), .disp_data_o(ddat),
    .cmd_byte_o(cmd), .cmd_valid_o(cmdv), .page_addr_o(pg), .column_addr_o(cl));
  tws_master_model i_master (.sda_i(sda), .scl_o(scl), .sda_low_o(mlow), .rx_o(rx),
    .rx_tgl_o(rxt));
  initial
  begin
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    samples_checked++;
    if (a !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, a, e);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // kinds: 0 address, 1 display port, 2 drive count, 3 link, 4 discarded
  task automatic note(input logic [2:0] k, input logic [15:0] v);
    nq.push_back({k, v});
    if (k < 3'h3)
    begin
      @(negedge clk);
      probe = ~probe;
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic ak);
    note(3'h3, {15'h0000, ak});
    i_master.xfer(1'b1, b, 1'b0);
  endtask
  task automatic hdr(input logic cd, input logic rw);
    i_master.start();
    wr({DEV_ADDR_PREFIX, cs, cd, rw}, ACK_GOOD);
  endtask
  task automatic setad(input logic [3:0] p, input logic [6:0] c);
    hdr(1'b0, 1'b0);
    cq.push_back({CMD_COL_LO, c[3:0]});
    wr({CMD_COL_LO, c[3:0]}, ACK_GOOD);
    cq.push_back({CMD_COL_HI, 1'b0, c[6:4]});
    wr({CMD_COL_HI, 1'b0, c[6:4]}, ACK_GOOD);
    cq.push_back({CMD_PAGE, p});
    wr({CMD_PAGE, p}, ACK_GOOD);
    i_master.stop();
    note(3'h0, {5'h00, p, c});
  endtask
  // n data bytes in one sequence, the last acked with ak
  task automatic dw(input int n, input logic ak);
    hdr(1'b1, 1'b0);
    for (int i = 1; i <= n; i++)
      wr(d, i == n ? ak : ACK_GOOD);
    i_master.stop();
  endtask
  task automatic dsp(input logic [3:0] p, input logic [6:0] c, input logic [7:0] e);
    @(posedge clk);
    dpg <= p;
    dcl <= c;
    repeat (2) @(posedge clk);
    note(3'h1, {8'h00, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(probe, rxt)
  begin
    logic [18:0] n;
    logic [15:0] a;
    if (nq.size() != 0)
    begin
      n = nq.pop_front();
      case (n[18:16])
        3'h0: a = {5'h00, pg, cl};
        3'h1: a = {8'h00, ddat};
        3'h2: a = {8'h00, oe_cnt};
        default: a = {8'h00, rx};
      endcase
      if (n[18:16] != 3'h4)
        cmp(a, n[15:0]);
    end
  end
  always @(posedge clk)
    if (cmdv === 1'b1)
      cmp({8'h00, cmd}, {8'h00, cq.pop_front()});
  always @(posedge sda_oe)
    oe_cnt <= oe_cnt + 8'h01;
  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t run did not finish", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rs = xs(rs);
    sel <= MODE_I2C;
    cs <= rs[1:0];
    repeat (10) @(posedge clk);
    // a foreign address must leave sda untouched
    i_master.start();
    wr({DEV_ADDR_PREFIX, ~cs, 2'b00}, 1'b1);
    i_master.stop();
    note(3'h2, 16'h0000);
    d = rs[15:8];
    wrp <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      dir <= i[0];
      setad(i ? 4'h0 : PAGE_LAST_GFX, COL_LAST);
      dw(1, ACK_GOOD);
      note(3'h0, {5'h00, i ? PAGE_LAST_GFX : 4'h0, 7'h00});
    end
    // wrap off: stuck at page end, extra byte refused
    wrp <= 1'b0;
    setad(PAGE_LAST_GFX, COL_LAST);
    dw(2, ACK_BAD);
    note(3'h0, {5'h00, PAGE_LAST_GFX, COL_END});
    wrp <= 1'b1;
    setad(PAGE_ICON, COL_LAST);
    dw(2, ACK_BAD);
    note(3'h0, {5'h00, PAGE_ICON, COL_END});
    // refused byte is sent again at a fresh address
    setad(4'h3, 7'h00);
    dw(1, ACK_GOOD);
    ord <= 1'b0;
    dw(1, ACK_GOOD);
    ord <= 1'b1;
    mir <= 1'b1;
    dw(1, ACK_GOOD);
    mir <= 1'b0;
    dsp(4'h3, 7'h00, d);
    dsp(4'h3, 7'h01, {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]});
    dsp(4'h3, COL_LAST - 7'h02, d);
    // read back: first byte is the pipe content and is dropped
    setad(4'h3, 7'h00);
    hdr(1'b1, 1'b1);
    note(3'h4, 16'h0000);
    i_master.xfer(1'b0, 8'h00, 1'b0);
    note(3'h3, {8'h00, d});
    i_master.xfer(1'b0, 8'h00, 1'b1);
    i_master.stop();
    repeat (5) @(posedge clk);
    report_and_stop();
  end
endmodule
